// ==== verilog/sbcomc_ctrl.v ====
// Purpose: Operating-mode controller of a CAN system basis chip
// Assumes: 20 MHz clk_sys; analog detectors arrive as asynchronous levels
// Notes:   Mode select writes arrive as a one-cycle strobe from the serial port logic
`timescale 1ns/10ps
`include "sbcomc_map.vh"

// Notes on behaviour
// - One state machine with seven modes: Normal, Standby, Sleep, Reset, FNormal, Overtemp, Off.
// - Standby goes to Normal on mode select write 111.
// - Normal goes to Standby on mode select write 100.
// - Standby: transceiver offline, serial port and supply on, watchdog timeout only.
// - Bus wake watched when enabled; selective only if both partial-net bits set.
// - Bus bias to ground after silence timeout, to mid level while active in any mode but Off and Overtemp.
// - Receive output forced low while a wake-up is pending and the transceiver is off.
// - Standby reached through Reset from Off, Overtemp, Sleep wake; directly from Normal on write 100.
// - Sleep: supply off, temperature protection and serial port off, biasing kept.
// - Sleep write taken from Normal/Standby only with no pending wake and a source enabled.
// - Illegal sleep request enters Reset with reset source code 10100.
// - Sleep left on enabled regular or diagnostic wake-up, or to Off on low battery.
// - Sleep disable bit set: sleep write raises serial failure, no transition.
// - Reset: reset pin low a defined time, traffic blocked, port and watchdog off.
// - Reset: aux output follows aux control and startup control bits.
// - Any reset source event moves Standby, Normal or Forced Normal to Reset.
// - Reset exits to Standby on pin release, Forced Normal if select set.
// - Reset entered by supply undervoltage holds until the supply recovers.
// - Off on first battery or low battery; only power-on detect; bus floating.
// - From Off, after power-on threshold and startup time, go to Reset.
// - Normal: supply on, CAN may be active, watchdog window/timeout, aux per settings.
// - Mode select field is bits 2:0 of register at serial address 0x01.
// - Overtemp entered at once from any mode but Off or Sleep on overheating.
// - Forced Normal: watchdog off, supply, aux output and transceiver active.
// - Reset from Forced Normal returns to Forced Normal, not Standby.
module sbcomc_ctrl (
  clk_sys,
  rst,
  bat_above_pon,
  bat_below_poff,
  temp_above_act,
  temp_below_rel,
  mcu_supply_uv,
  reset_pin_in,
  wake_pin_event,
  can_rx_activity,
  selective_wake_frame,
  diag_wake_event,
  ext_reset_event,
  wdt_reset_event,
  mode_wr,
  mode_wr_addr,
  mode_wr_data,
  can_wake_enable,
  local_wake_enable,
  partial_net_enable,
  partial_net_config_valid,
  sleep_disable_bit,
  forced_normal_select,
  aux_output_control,
  aux_output_startup_control,
  can_normal_request,
  wake_clear,
  op_mode,
  mode_select_field,
  reset_source_code,
  reset_pin_low_active,
  reset_pin_oe_n,
  mcu_supply_en,
  aux_output_en,
  spi_enable,
  wdt_enable,
  wdt_window_allowed,
  temp_protect_en,
  can_tx_rx_en,
  can_bias_mid,
  can_pins_floating,
  rxd_force_low,
  wake_pending,
  spi_fail_event
);
  input  wire       clk_sys;
  input  wire       rst;
  input  wire       bat_above_pon;
  input  wire       bat_below_poff;
  input  wire       temp_above_act;
  input  wire       temp_below_rel;
  input  wire       mcu_supply_uv;
  input  wire       reset_pin_in;
  input  wire       wake_pin_event;
  input  wire       can_rx_activity;
  input  wire       selective_wake_frame;
  input  wire       diag_wake_event;
  input  wire       ext_reset_event;
  input  wire       wdt_reset_event;
  input  wire       mode_wr;
  input  wire [6:0] mode_wr_addr;
  input  wire [2:0] mode_wr_data;
  input  wire       can_wake_enable;
  input  wire       local_wake_enable;
  input  wire       partial_net_enable;
  input  wire       partial_net_config_valid;
  input  wire       sleep_disable_bit;
  input  wire       forced_normal_select;
  input  wire       aux_output_control;
  input  wire       aux_output_startup_control;
  input  wire       can_normal_request;
  input  wire       wake_clear;
  output reg  [2:0] op_mode;
  output reg  [2:0] mode_select_field;
  output reg  [4:0] reset_source_code;
  output reg        reset_pin_low_active;
  output reg        reset_pin_oe_n;
  output reg        mcu_supply_en;
  output reg        aux_output_en;
  output reg        spi_enable;
  output reg        wdt_enable;
  output reg        wdt_window_allowed;
  output reg        temp_protect_en;
  output reg        can_tx_rx_en;
  output reg        can_bias_mid;
  output reg        can_pins_floating;
  output reg        rxd_force_low;
  output reg        wake_pending;
  output reg        spi_fail_event;

  localparam [2:0] M_OFF      = `SBCOMC_M_OFF;
  localparam [2:0] M_RESET    = `SBCOMC_M_RESET;
  localparam [2:0] M_STANDBY  = `SBCOMC_M_STANDBY;
  localparam [2:0] M_NORMAL   = `SBCOMC_M_NORMAL;
  localparam [2:0] M_SLEEP    = `SBCOMC_M_SLEEP;
  localparam [2:0] M_FNORMAL  = `SBCOMC_M_FNORMAL;
  localparam [2:0] M_OVERTEMP = `SBCOMC_M_OVERTEMP;
  localparam [24:0] STARTUP_CYC = `SBCOMC_STARTUP_CYC;
  localparam [24:0] RESET_CYC   = `SBCOMC_RESET_CYC;

  // Silence timeout exceeds 4096 cycles, so it may be shortened in simulation
  parameter [24:0] SILENCE_CYC = `SBCOMC_SILENCE_CYC;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  wire [13:0] sync_out;

  sbcomc_sync #(
    .WIDTH (14)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     ({bat_above_pon, bat_below_poff, temp_above_act, temp_below_rel,
                mcu_supply_uv, reset_pin_in, wake_pin_event, can_rx_activity,
                selective_wake_frame, diag_wake_event, ext_reset_event,
                wdt_reset_event, 2'h0}),
    .dout    (sync_out)
  );

  wire s_pon     = sync_out[13];
  wire s_poff    = sync_out[12];
  wire s_hot     = sync_out[11];
  wire s_cool    = sync_out[10];
  wire s_uv      = sync_out[9];
  wire s_rstpin  = sync_out[8];
  wire s_wake    = sync_out[7];
  wire s_busact  = sync_out[6];
  wire s_selwake = sync_out[5];
  wire s_diag    = sync_out[4];
  wire s_extrst  = sync_out[3];
  wire s_wdtrst  = sync_out[2];

  // ----------------------------------------------------------------
  // Bus activity, wake-up detection and biasing
  // ----------------------------------------------------------------
  reg        busact_d;
  reg [24:0] silence_cnt;
  reg        uv_reset;
  reg        from_fnormal;
  reg [24:0] timer;
  reg [2:0]  next_mode;
  reg [4:0]  next_rss;
  reg        sleep_req_ok;

  wire bus_edge = s_busact & ~busact_d;
  wire can_wake_hit = can_wake_enable &
                      ((partial_net_enable & partial_net_config_valid) ? s_selwake : bus_edge);
  wire wake_watch   = (op_mode == M_STANDBY) | (op_mode == M_SLEEP) | (op_mode == M_RESET);
  wire wake_hit     = wake_watch & (can_wake_hit | (local_wake_enable & s_wake) | s_diag);
  wire reset_event  = s_extrst | s_wdtrst | s_uv;
  wire mc_write     = mode_wr & (mode_wr_addr == `SBCOMC_MC_ADDR);

  // Mode select code is one of the three defined codes
  function mc_defined;
    input [2:0] code;
    begin
      mc_defined = (code == `SBCOMC_MC_SLEEP) | (code == `SBCOMC_MC_STANDBY) |
                   (code == `SBCOMC_MC_NORMAL);
    end
  endfunction

  always @(posedge clk_sys) begin
    if (rst) begin
      busact_d     <= 1'b0;
      silence_cnt  <= 25'h0000000;
      can_bias_mid <= 1'b0;
      wake_pending <= 1'b0;
    end else begin
      busact_d <= s_busact;
      if (s_busact) begin
        silence_cnt  <= 25'h0000000;
        can_bias_mid <= (op_mode != M_OFF) & (op_mode != M_OVERTEMP);
      end else if (silence_cnt >= SILENCE_CYC) begin
        can_bias_mid <= 1'b0;
      end else begin
        silence_cnt <= silence_cnt + 25'h0000001;
      end
      // pending wake, set wins over clear
      if (wake_hit) begin
        wake_pending <= 1'b1;
      end else if (wake_clear) begin
        wake_pending <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  always @* begin
    next_mode    = op_mode;
    next_rss     = reset_source_code;
    sleep_req_ok = ~wake_pending & ~wake_hit & (can_wake_enable | local_wake_enable);
    case (op_mode)
      M_OFF: begin
        if (s_pon & ~s_poff & (timer >= STARTUP_CYC)) begin
          next_mode = M_RESET;
          next_rss  = `SBCOMC_RSS_POWERON;
        end
      end
      M_RESET: begin
        if (~(uv_reset & s_uv) & (timer >= RESET_CYC) & s_rstpin) begin
          if (forced_normal_select | from_fnormal) begin
            next_mode = M_FNORMAL;
          end else begin
            next_mode = M_STANDBY;
          end
        end
      end
      M_STANDBY, M_NORMAL: begin
        if (reset_event) begin
          next_mode = M_RESET;
          next_rss  = s_uv ? `SBCOMC_RSS_UNDERVOLT : `SBCOMC_RSS_EXTERNAL;
        end else if (mc_write & mc_defined(mode_wr_data)) begin
          if ((op_mode == M_STANDBY) & (mode_wr_data == `SBCOMC_MC_NORMAL)) begin
            next_mode = M_NORMAL;
          end else if ((op_mode == M_NORMAL) & (mode_wr_data == `SBCOMC_MC_STANDBY)) begin
            next_mode = M_STANDBY;
          end else if ((mode_wr_data == `SBCOMC_MC_SLEEP) & ~sleep_disable_bit) begin
            if (sleep_req_ok) begin
              next_mode = M_SLEEP;
            end else begin
              next_mode = M_RESET;
              next_rss  = `SBCOMC_RSS_ILLSLEEP;
            end
          end
        end
      end
      M_SLEEP: begin
        if (wake_hit) begin
          next_mode = M_RESET;
          next_rss  = `SBCOMC_RSS_WAKE;
        end
      end
      M_FNORMAL: begin
        if (reset_event) begin
          next_mode = M_RESET;
          next_rss  = s_uv ? `SBCOMC_RSS_UNDERVOLT : `SBCOMC_RSS_EXTERNAL;
        end
      end
      M_OVERTEMP: begin
        if (s_cool & ~s_hot) begin
          next_mode = M_RESET;
          next_rss  = `SBCOMC_RSS_OVERTEMP;
        end
      end
      default: begin
        next_mode = M_OFF;
      end
    endcase
    if (s_hot & (op_mode != M_OFF) & (op_mode != M_SLEEP)) begin
      next_mode = M_OVERTEMP;
    end
    if (s_poff) begin
      next_mode = M_OFF;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      op_mode           <= M_OFF;
      reset_source_code <= `SBCOMC_RSS_NONE;
      mode_select_field <= `SBCOMC_MC_RESET;
      timer             <= 25'h0000000;
      uv_reset          <= 1'b0;
      from_fnormal      <= 1'b0;
      spi_fail_event    <= 1'b0;
    end else begin
      op_mode           <= next_mode;
      reset_source_code <= next_rss;
      spi_fail_event    <= mc_write & (mode_wr_data == `SBCOMC_MC_SLEEP) & sleep_disable_bit &
                           ((op_mode == M_STANDBY) | (op_mode == M_NORMAL));
      if (mc_write & mc_defined(mode_wr_data) & (next_mode != op_mode)) begin
        mode_select_field <= mode_wr_data;
      end else if (next_mode == M_STANDBY) begin
        mode_select_field <= `SBCOMC_MC_STANDBY;
      end
      if ((next_mode != op_mode) | ((op_mode == M_OFF) & ~s_pon)) begin
        timer <= 25'h0000000;
      end else if (timer != 25'h1FFFFFF) begin
        timer <= timer + 25'h0000001;
      end
      if ((next_mode == M_RESET) & (op_mode != M_RESET)) begin
        uv_reset     <= s_uv;
        from_fnormal <= (op_mode == M_FNORMAL);
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-mode outputs
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      reset_pin_low_active <= 1'b0;
      reset_pin_oe_n       <= 1'b0;
      mcu_supply_en        <= 1'b0;
      aux_output_en        <= 1'b0;
      spi_enable           <= 1'b0;
      wdt_enable           <= 1'b0;
      wdt_window_allowed   <= 1'b0;
      temp_protect_en      <= 1'b0;
      can_tx_rx_en         <= 1'b0;
      can_pins_floating    <= 1'b1;
      rxd_force_low        <= 1'b0;
    end else begin
      // reset pin low, released after reset time
      reset_pin_oe_n       <= (op_mode == M_STANDBY) | (op_mode == M_NORMAL) |
                              (op_mode == M_FNORMAL) | ((op_mode == M_RESET) &
                              (timer >= RESET_CYC) & ~(uv_reset & s_uv));
      reset_pin_low_active <= 1'b0;
      mcu_supply_en   <= (op_mode != M_OFF) & (op_mode != M_SLEEP) & (op_mode != M_OVERTEMP);
      spi_enable      <= (op_mode == M_STANDBY) | (op_mode == M_NORMAL) |
                         (op_mode == M_FNORMAL);
      temp_protect_en <= (op_mode != M_OFF) & (op_mode != M_SLEEP);
      wdt_enable         <= (op_mode == M_STANDBY) | (op_mode == M_NORMAL) |
                            (op_mode == M_SLEEP);
      wdt_window_allowed <= (op_mode == M_NORMAL);
      can_tx_rx_en       <= (op_mode == M_FNORMAL) |
                            ((op_mode == M_NORMAL) & can_normal_request);
      can_pins_floating  <= (op_mode == M_OFF) | (op_mode == M_OVERTEMP);
      case (op_mode)
        M_OFF:      aux_output_en <= 1'b0;
        M_FNORMAL:  aux_output_en <= 1'b1;
        M_OVERTEMP: aux_output_en <= aux_output_en;
        M_RESET:    aux_output_en <= aux_output_control | aux_output_startup_control;
        default:    aux_output_en <= aux_output_control;
      endcase
      rxd_force_low <= wake_pending & ~can_tx_rx_en;
    end
  end
endmodule

// ==== common/sbcomc_map.vh ====
// Purpose: Constants for the operating-mode controller
// Assumes: 20 MHz system clock
// Notes:   Mode codes, mode select codes, reset source codes, timings
`ifndef SBCOMC_MAP_VH
`define SBCOMC_MAP_VH

// Operating modes (state codes)
`define SBCOMC_M_OFF      3'h0
`define SBCOMC_M_RESET    3'h1
`define SBCOMC_M_STANDBY  3'h2
`define SBCOMC_M_NORMAL   3'h3
`define SBCOMC_M_SLEEP    3'h4
`define SBCOMC_M_FNORMAL  3'h5
`define SBCOMC_M_OVERTEMP 3'h6

// Mode select field (bits 2:0 of mode control register, serial address 0x01)
`define SBCOMC_MC_ADDR    7'h01
`define SBCOMC_MC_SLEEP   3'h1
`define SBCOMC_MC_STANDBY 3'h4
`define SBCOMC_MC_NORMAL  3'h7
`define SBCOMC_MC_RESET   3'h4

// Reset source codes
`define SBCOMC_RSS_WIDTH     5
`define SBCOMC_RSS_NONE      5'h00
`define SBCOMC_RSS_POWERON   5'h01
`define SBCOMC_RSS_EXTERNAL  5'h02
`define SBCOMC_RSS_UNDERVOLT 5'h03
`define SBCOMC_RSS_WAKE      5'h04
`define SBCOMC_RSS_OVERTEMP  5'h05
`define SBCOMC_RSS_ILLSLEEP  5'h14

// Timing (system clock in kHz, times in us)
`define SBCOMC_CLK_KHZ       20000
`define SBCOMC_T_STARTUP_US  2800
`define SBCOMC_T_RESET_US    20
`define SBCOMC_T_SILENCE_US  1000000
// Cycle counts of the times above at clk_sys, sized to the timer width
`define SBCOMC_STARTUP_CYC   25'h000DAC0
`define SBCOMC_RESET_CYC     25'h0000190
`define SBCOMC_SILENCE_CYC   25'h1312D00
`define SBCOMC_CNT_WIDTH     25

`endif

// ==== verilog/sbcomc_sync.v ====
// Purpose: Two-flip-flop synchroniser for a group of asynchronous inputs
// Assumes: Inputs are levels from outside the clock domain
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
module sbcomc_sync #(
  parameter WIDTH = 1
) (
  clk_sys,
  rst,
  din,
  dout
);
  input  wire             clk_sys;
  input  wire             rst;
  input  wire [WIDTH-1:0] din;
  output reg  [WIDTH-1:0] dout;

  reg [WIDTH-1:0] stage1;

  always @(posedge clk_sys) begin
    if (rst) begin
      stage1 <= {WIDTH{1'b0}};
      dout   <= {WIDTH{1'b0}};
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

// ==== sim/sbcomc_ctrl_assertions.sv ====
// Purpose: Port-level checks on the operating-mode controller
// Assumes: Fault inputs are quiet around mode writes
// Notes:   Bound to every instance of sbcomc_ctrl
`timescale 1ns/10ps
`include "sbcomc_map.vh"
module sbcomc_ctrl_checker (
  input wire       clk_sys,
  input wire       rst,
  input wire       bat_below_poff,
  input wire       temp_above_act,
  input wire       mcu_supply_uv,
  input wire       ext_reset_event,
  input wire       wdt_reset_event,
  input wire       mode_wr,
  input wire [6:0] mode_wr_addr,
  input wire [2:0] mode_wr_data,
  input wire       can_wake_enable,
  input wire       local_wake_enable,
  input wire       sleep_disable_bit,
  input wire [2:0] op_mode,
  input wire [2:0] mode_select_field,
  input wire [4:0] reset_source_code,
  input wire       reset_pin_oe_n,
  input wire       mcu_supply_en,
  input wire       spi_enable,
  input wire       temp_protect_en,
  input wire       wdt_enable,
  input wire       spi_fail_event
);
  logic [9:0] rst_cycles;
  wire        quiet = !(temp_above_act | bat_below_poff | mcu_supply_uv | ext_reset_event
                        | wdt_reset_event);
  wire        wr1 = mode_wr && (mode_wr_addr == `SBCOMC_MC_ADDR) && quiet;
  wire        awake = (op_mode == `SBCOMC_M_STANDBY) || (op_mode == `SBCOMC_M_NORMAL);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Cycles spent in Reset
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (rst || op_mode != `SBCOMC_M_RESET)
      rst_cycles <= 10'h000;
    else if (rst_cycles != 10'h3FF)
      rst_cycles <= rst_cycles + 10'h001;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_standby_to_normal: assert property (
    wr1 && mode_wr_data == `SBCOMC_MC_NORMAL && op_mode == `SBCOMC_M_STANDBY
    |=> op_mode == `SBCOMC_M_NORMAL && mode_select_field == `SBCOMC_MC_NORMAL)
    else $error("normal entry missed");
  a_normal_to_standby: assert property (
    wr1 && mode_wr_data == `SBCOMC_MC_STANDBY && op_mode == `SBCOMC_M_NORMAL
    |=> op_mode == `SBCOMC_M_STANDBY)
    else $error("standby entry missed");
  a_sleep_disabled: assert property (
    wr1 && mode_wr_data == `SBCOMC_MC_SLEEP && sleep_disable_bit && awake
    |=> spi_fail_event && $stable(op_mode))
    else $error("disabled sleep not refused");
  a_illegal_sleep: assert property (
    wr1 && mode_wr_data == `SBCOMC_MC_SLEEP && !sleep_disable_bit && awake
    && !can_wake_enable && !local_wake_enable
    |=> op_mode == `SBCOMC_M_RESET ##1 reset_source_code == `SBCOMC_RSS_ILLSLEEP)
    else $error("illegal sleep not sent to reset");
  a_reset_pin_low: assert property (
    op_mode == `SBCOMC_M_RESET && $past(op_mode) == `SBCOMC_M_RESET
    && rst_cycles < 10'h12C |-> !reset_pin_oe_n)
    else $error("reset pin not driven");
  a_reset_min_time: assert property (
    op_mode == `SBCOMC_M_STANDBY && $past(op_mode) == `SBCOMC_M_RESET
    |-> rst_cycles >= `SBCOMC_RESET_CYC)
    else $error("reset left too early");
  a_sleep_outputs: assert property (
    op_mode == `SBCOMC_M_SLEEP && $past(op_mode) == `SBCOMC_M_SLEEP
    |-> !mcu_supply_en && !spi_enable && !temp_protect_en)
    else $error("sleep outputs wrong");
  a_fnormal_wdt_off: assert property (
    op_mode == `SBCOMC_M_FNORMAL && $past(op_mode) == `SBCOMC_M_FNORMAL
    |-> !wdt_enable && mcu_supply_en)
    else $error("forced normal outputs wrong");
  a_overtemp_entry: assert property (
    awake && temp_above_act && !bat_below_poff |-> ##[1:4] op_mode == `SBCOMC_M_OVERTEMP)
    else $error("overtemp not entered");
  a_low_battery_off: assert property (
    bat_below_poff |-> ##[1:4] op_mode == `SBCOMC_M_OFF)
    else $error("off not entered");
endmodule
bind sbcomc_ctrl sbcomc_ctrl_checker i_sbcomc_ctrl_checker (.clk_sys, .rst, .bat_below_poff,
  .temp_above_act, .mcu_supply_uv, .ext_reset_event, .wdt_reset_event, .mode_wr, .mode_wr_addr,
  .mode_wr_data, .can_wake_enable, .local_wake_enable, .sleep_disable_bit, .op_mode,
  .mode_select_field, .reset_source_code, .reset_pin_oe_n, .mcu_supply_en, .spi_enable,
  .temp_protect_en, .wdt_enable, .spi_fail_event);

// ==== sim/sbcomc_bus_model.sv ====
// Purpose: Bus-side activity source for the mode controller
// Assumes: Bit time 200 ns, unrelated in phase to clk_sys
// Notes:   Line rests inactive between frames
`timescale 1ns/10ps
module sbcomc_bus_model (
  input  wire frame_req,
  output reg  can_rx_activity
);
  integer i;
  initial begin
    can_rx_activity = 1'b0;
    forever begin
      @(posedge frame_req);
      #137;
      for (i = 0; i < 12; i = i + 1) begin
        can_rx_activity = ~can_rx_activity;
        #200;
      end
      can_rx_activity = 1'b0;
    end
  end
endmodule

// ==== sim/sbcomc_ctrl_tb_top.sv ====
// Purpose: Self-checking bench for the operating-mode controller
// Assumes: 20 MHz clock, inputs driven 1 ns after the rising edge
// Notes:   Short silence count; reset pin level resolved from the driver
`timescale 1ns/10ps
`include "sbcomc_map.vh"
module sbcomc_ctrl_tb_top;
  localparam [2:0] OFF = `SBCOMC_M_OFF, RSTM = `SBCOMC_M_RESET, STBY = `SBCOMC_M_STANDBY;
  localparam [2:0] NORM = `SBCOMC_M_NORMAL, SLP = `SBCOMC_M_SLEEP, FNRM = `SBCOMC_M_FNORMAL;
  localparam [2:0] OVT = `SBCOMC_M_OVERTEMP, C_SLP = 3'h1, C_STB = 3'h4, C_NRM = 3'h7;
  logic        clk_sys, rst, bat_above_pon, bat_below_poff, temp_above_act, temp_below_rel;
  logic        mcu_supply_uv, wake_pin_event, selective_wake_frame, diag_wake_event;
  logic        ext_reset_event, wdt_reset_event, mode_wr, can_wake_enable, local_wake_enable;
  logic        partial_net_enable, partial_net_config_valid, sleep_disable_bit;
  logic        forced_normal_select, aux_output_control, aux_output_startup_control;
  logic        can_normal_request, wake_clear, frame_req;
  logic [6:0]  mode_wr_addr;
  logic [2:0]  mode_wr_data, code, exp_mode;
  logic [31:0] lfsr_state;
  wire  [2:0]  op_mode, mode_select_field;
  wire  [4:0]  reset_source_code;
  wire         reset_pin_low_active, reset_pin_oe_n, mcu_supply_en, aux_output_en, spi_enable;
  wire         wdt_enable, wdt_window_allowed, temp_protect_en, can_tx_rx_en, can_bias_mid;
  wire         can_pins_floating, rxd_force_low, wake_pending, spi_fail_event, can_rx_activity;
  wire         reset_pin_in = reset_pin_oe_n ? 1'b1 : reset_pin_low_active;
  integer      miscompares, checks_done, i;
  sbcomc_ctrl #(.SILENCE_CYC(25'h0000032)) i_sbcomc_ctrl (.clk_sys, .rst, .bat_above_pon,
    .bat_below_poff, .temp_above_act, .temp_below_rel, .mcu_supply_uv, .reset_pin_in,
    .wake_pin_event, .can_rx_activity, .selective_wake_frame, .diag_wake_event,
    .ext_reset_event, .wdt_reset_event, .mode_wr, .mode_wr_addr, .mode_wr_data,
    .can_wake_enable, .local_wake_enable, .partial_net_enable, .partial_net_config_valid,
    .sleep_disable_bit, .forced_normal_select, .aux_output_control, .aux_output_startup_control,
    .can_normal_request, .wake_clear, .op_mode, .mode_select_field, .reset_source_code,
    .reset_pin_low_active, .reset_pin_oe_n, .mcu_supply_en, .aux_output_en, .spi_enable,
    .wdt_enable, .wdt_window_allowed, .temp_protect_en, .can_tx_rx_en, .can_bias_mid,
    .can_pins_floating, .rxd_force_low, .wake_pending, .spi_fail_event);
  sbcomc_bus_model i_sbcomc_bus_model (.frame_req(frame_req), .can_rx_activity(can_rx_activity));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [2:0] exp_next(input logic [2:0] m, input logic [2:0] c,
                                          input logic hit);
    exp_next = m;
    if (hit && m == STBY && c == C_NRM) exp_next = NORM;
    if (hit && m == NORM && c == C_STB) exp_next = STBY;
  endfunction
  task conclude;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task waitm(input logic [2:0] m, input integer n);
    integer k;
    k = 0;
    while (op_mode !== m && k < n) begin
      tick(1);
      k = k + 1;
    end
    chk(op_mode, m);
    if (op_mode !== m) conclude();
  endtask
  task wr(input logic [2:0] c);
    mode_wr = 1'b1;
    mode_wr_data = c;
    tick(1);
    mode_wr = 1'b0;
  endtask
  task pulse_reset;
    ext_reset_event = 1'b1;
    tick(3);
    ext_reset_event = 1'b0;
  endtask
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    {bat_above_pon, bat_below_poff, temp_above_act, temp_below_rel, mcu_supply_uv} = 5'h00;
    {wake_pin_event, selective_wake_frame, diag_wake_event, ext_reset_event} = 4'h0;
    {wdt_reset_event, mode_wr, can_wake_enable, local_wake_enable, partial_net_enable} = 5'h00;
    {partial_net_config_valid, sleep_disable_bit, forced_normal_select} = 3'h0;
    {aux_output_control, aux_output_startup_control, can_normal_request, wake_clear} = 4'h0;
    {frame_req, mode_wr_addr, mode_wr_data} = 11'h008;
    {miscompares, checks_done, lfsr_state, rst} = {32'h0, 32'h0, 32'h4FE98292, 1'b1};
    tick(10);
    rst = 1'b0;
    chk(op_mode, OFF);
    chk(mode_select_field, C_STB);
    chk(can_pins_floating, 1'b1);
    bat_above_pon = 1'b1;
    waitm(RSTM, 60000);
    chk(reset_source_code, `SBCOMC_RSS_POWERON);
    tick(2);
    chk(reset_pin_oe_n, 1'b0);
    waitm(STBY, 1000);
    tick(1);
    chk({can_tx_rx_en, spi_enable, mcu_supply_en}, 3'h3);
    $display("power-up test done");
    wr(C_NRM);
    chk(op_mode, NORM);
    tick(1);
    chk({mcu_supply_en, spi_enable, wdt_window_allowed}, 3'h7);
    wr(C_NRM);
    chk(op_mode, NORM);
    tick(1);
    wr(C_STB);
    chk(op_mode, STBY);
    exp_mode = STBY;
    for (i = 0; i < 16; i = i + 1) begin
      tick(1);
      lfsr_state = lfsr_next(lfsr_state);
      code = (lfsr_state[2:0] == C_SLP) ? 3'h5 : lfsr_state[2:0];
      mode_wr_addr = lfsr_state[3] ? 7'h01 : 7'h05;
      {aux_output_control, aux_output_startup_control} = lfsr_state[5:4];
      {can_normal_request, partial_net_enable} = lfsr_state[7:6];
      exp_mode = exp_next(exp_mode, code, lfsr_state[3]);
      wr(code);
      chk(op_mode, exp_mode);
    end
    {mode_wr_addr, partial_net_enable} = 8'h02;
    tick(1);
    if (exp_mode == NORM) wr(C_STB);
    $display("mode write test done");
    tick(1);
    sleep_disable_bit = 1'b1;
    wr(C_SLP);
    chk({spi_fail_event, op_mode}, {1'b1, STBY});
    sleep_disable_bit = 1'b0;
    tick(1);
    wr(C_SLP);
    chk(op_mode, RSTM);
    tick(1);
    chk(reset_source_code, `SBCOMC_RSS_ILLSLEEP);
    waitm(STBY, 1000);
    $display("sleep refusal test done");
    can_wake_enable = 1'b1;
    wr(C_SLP);
    chk(op_mode, SLP);
    tick(2);
    chk({mcu_supply_en, spi_enable, temp_protect_en}, 3'h0);
    frame_req = 1'b1;
    waitm(RSTM, 200);
    tick(2);
    chk({rxd_force_low, reset_source_code}, {1'b1, `SBCOMC_RSS_WAKE});
    chk(can_bias_mid, 1'b1);
    frame_req = 1'b0;
    waitm(STBY, 1000);
    chk(can_bias_mid, 1'b0);
    {wake_clear, can_wake_enable} = 2'h2;
    tick(2);
    wake_clear = 1'b0;
    chk({wake_pending, rxd_force_low}, 2'h0);
    $display("sleep wake test done");
    temp_above_act = 1'b1;
    waitm(OVT, 10);
    {temp_above_act, temp_below_rel} = 2'h1;
    waitm(RSTM, 10);
    temp_below_rel = 1'b0;
    waitm(STBY, 1000);
    $display("overtemp test done");
    forced_normal_select = 1'b1;
    pulse_reset();
    waitm(RSTM, 10);
    waitm(FNRM, 1000);
    tick(1);
    chk({wdt_enable, mcu_supply_en, aux_output_en}, 3'h3);
    forced_normal_select = 1'b0;
    wdt_reset_event = 1'b1;
    tick(3);
    wdt_reset_event = 1'b0;
    waitm(RSTM, 10);
    waitm(FNRM, 1000);
    mcu_supply_uv = 1'b1;
    waitm(RSTM, 10);
    tick(600);
    chk(op_mode, RSTM);
    mcu_supply_uv = 1'b0;
    waitm(FNRM, 1000);
    $display("forced normal test done");
    {bat_below_poff, bat_above_pon} = 2'h2;
    waitm(OFF, 10);
    tick(2);
    chk(can_pins_floating, 1'b1);
    $display("power-off test done");
    conclude();
  end
endmodule
